// *** rtl/cps_map.vh ***
// constants of the camera pixel serializer
`ifndef CPS_MAP_VH
`define CPS_MAP_VH

`define CPS_FRAME_BITS 28
`define CPS_PAY_NARROW 6'd24
`define CPS_PAY_WIDE 6'd21
`define CPS_PIX_NARROW 6'd12
`define CPS_PIX_WIDE 6'd14
`define CPS_MASK_NARROW 24'hffffff
`define CPS_MASK_WIDE 24'h1fffff
`define CPS_SYS_CLK_KHZ 250000
`define CPS_LOCK_TIME_US 1000
`define CPS_LOCK_CYCLES (`CPS_LOCK_TIME_US * (`CPS_SYS_CLK_KHZ / 1000))
`define CPS_ACT_TIMEOUT 256
`define CPS_BIT_DIV 2
`define CPS_SYNC_W 20
// pixels held back so the serial output lags the bus by a fixed pixel count
`define CPS_DELAY_PIX 4'd12

`endif

// *** rtl/cps_serializer.v ***
// camera pixel serializer: capture, framing, balance coding, pll lock model
`timescale 1ns/10ps
`default_nettype none
`include "cps_map.vh"

// Functional notes
// - In wide mode each captured pixel carries twelve data bits plus both sync bits.
// - In narrow mode each captured pixel carries ten data bits plus both sync bits.
// - Pixels and control-channel bits merge into one stream with clock marker and balance.
// - Every frame is 28 bits, one per two pixels narrow and two per three pixels wide.
// - The lock model takes its reference from the oscillator pin or the pixel clock.
// - After power-up with an active reference, lock is declared after the lock time.
// - Input-to-output latency stays within the documented pixel-period bound per mode.
// - Data is captured on the rising pixel clock edge when edge select is 1, else falling.
// - While power_down_n is low the serial output is held static high.
// - Each frame carries one parity bit over its payload and control bit.
module cps_serializer #(
    parameter LOCK_CYCLES = `CPS_LOCK_CYCLES,
    parameter ACT_TIMEOUT = `CPS_ACT_TIMEOUT,
    parameter BIT_DIV = `CPS_BIT_DIV
) (
    input wire sys_clk,
    input wire rst_n,
    input wire pixel_clk,
    input wire osc_clk,
    input wire power_down_n,
    input wire capture_edge_select,
    input wire wide_mode,
    input wire ref_select_osc,
    input wire line_sync,
    input wire frame_sync,
    input wire [11:0] pixel_data,
    input wire ctrl_bit,
    output reg ctrl_taken,
    output reg pll_locked,
    output reg ser_out
);

    // number of ones minus zeros over a 24-bit payload
    function signed [6:0] disparity;
        input [23:0] w;
        integer i;
        reg signed [6:0] d;
        begin
            d = 7'sd0;
            for (i = 0; i < 24; i = i + 1) begin
                d = w[i] ? d + 7'sd1 : d - 7'sd1;
            end
            disparity = d;
        end
    endfunction

    // two-stage synchroniser for every pin except sys_clk, rst_n and ctrl_bit
    reg [`CPS_SYNC_W-1:0] sync1;
    reg [`CPS_SYNC_W-1:0] sync2;
    wire [`CPS_SYNC_W-1:0] pins;
    assign pins = {pixel_clk, osc_clk, power_down_n, capture_edge_select, wide_mode,
                   ref_select_osc, line_sync, frame_sync, pixel_data};

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= {`CPS_SYNC_W{1'b0}};
            sync2 <= {`CPS_SYNC_W{1'b0}};
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
        end
    end

    wire s_pclk = sync2[19];
    wire s_osc = sync2[18];
    wire s_pdn = sync2[17];
    wire s_edge = sync2[16];
    wire s_wide = sync2[15];
    wire s_ref = sync2[14];
    wire s_hs = sync2[13];
    wire s_vs = sync2[12];
    wire [11:0] s_data = sync2[11:0];

    reg pclk_q;
    reg osc_q;
    wire pclk_rise = s_pclk & ~pclk_q;
    wire pclk_fall = ~s_pclk & pclk_q;
    wire osc_edge = s_osc ^ osc_q;
    wire capture = s_edge ? pclk_rise : pclk_fall;
    wire ref_edge = s_ref ? osc_edge : (pclk_rise | pclk_fall);

    // reference activity watchdog and lock timer
    reg [31:0] act_cnt;
    reg [31:0] lock_cnt;
    wire ref_alive = (act_cnt < ACT_TIMEOUT);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pclk_q <= 1'b0;
            osc_q <= 1'b0;
            act_cnt <= 32'hffffffff;
            lock_cnt <= 32'h0;
            pll_locked <= 1'b0;
        end else begin
            pclk_q <= s_pclk;
            osc_q <= s_osc;
            if (ref_edge) begin
                act_cnt <= 32'h0;
            end else if (act_cnt != 32'hffffffff) begin
                act_cnt <= act_cnt + 32'h1;
            end
            if (!s_pdn || !ref_alive) begin
                lock_cnt <= 32'h0;
                pll_locked <= 1'b0;
            end else if (lock_cnt < LOCK_CYCLES - 1) begin
                lock_cnt <= lock_cnt + 32'h1;
            end else begin
                pll_locked <= 1'b1;
            end
        end
    end

    // fixed pixel delay line; keeps the wide-mode latency above its lower bound
    localparam [3:0] DELAY_PIX = `CPS_DELAY_PIX;
    reg [13:0] dly_mem [0:DELAY_PIX-1];
    reg [3:0] dly_ptr;
    reg [3:0] dly_fill;
    wire [13:0] cap_word = {s_hs, s_vs, s_data};
    wire [13:0] old_word = dly_mem[dly_ptr];
    wire word_out = capture && (dly_fill == DELAY_PIX);

    always @(posedge sys_clk) begin
        if (pll_locked && capture) begin
            dly_mem[dly_ptr] <= cap_word;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dly_ptr <= 4'd0;
            dly_fill <= 4'd0;
        end else if (!pll_locked) begin
            dly_ptr <= 4'd0;
            dly_fill <= 4'd0;
        end else if (capture) begin
            dly_ptr <= (dly_ptr == DELAY_PIX - 4'd1) ? 4'd0 : dly_ptr + 4'd1;
            if (dly_fill != DELAY_PIX) begin
                dly_fill <= dly_fill + 4'd1;
            end
        end
    end

    // pixel packing into frame payloads
    reg [47:0] acc;
    reg [5:0] acc_cnt;
    reg [27:0] frame_hold;
    reg frame_full;
    reg signed [6:0] run_disp;
    reg frame_load;

    reg [47:0] next_acc;
    reg [5:0] next_cnt;
    reg [5:0] need;
    reg [23:0] pay;
    reg signed [6:0] pd;
    reg inv;
    reg emit;

    always @* begin
        need = s_wide ? `CPS_PAY_WIDE : `CPS_PAY_NARROW;
        if (s_wide) begin
            next_acc = {acc[33:0], old_word};
            next_cnt = acc_cnt + `CPS_PIX_WIDE;
        end else begin
            next_acc = {acc[35:0], old_word[13:12], old_word[9:0]};
            next_cnt = acc_cnt + `CPS_PIX_NARROW;
        end
        emit = word_out && (next_cnt >= need);
        pay = next_acc[23:0];
        if (next_cnt >= need) begin
            pay = next_acc[(next_cnt - need) +: 24];
        end
        pay = pay & (s_wide ? `CPS_MASK_WIDE : `CPS_MASK_NARROW);
        pd = disparity(pay);
        inv = (pd != 7'sd0) && (pd[6] == run_disp[6]) && (run_disp != 7'sd0);
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= 48'h0;
            acc_cnt <= 6'd0;
            frame_hold <= 28'h0;
            frame_full <= 1'b0;
            run_disp <= 7'sd0;
            ctrl_taken <= 1'b0;
        end else begin
            ctrl_taken <= 1'b0;
            if (!pll_locked) begin
                acc_cnt <= 6'd0;
                frame_full <= 1'b0;
                run_disp <= 7'sd0;
            end else begin
                if (frame_load) begin
                    frame_full <= 1'b0;
                end
                if (word_out) begin
                    acc <= next_acc;
                    acc_cnt <= emit ? next_cnt - need : next_cnt;
                end
                if (emit) begin
                    // marker, invert flag, control bit, parity, payload
                    frame_hold <= {1'b1, inv, ctrl_bit, ^{ctrl_bit, pay},
                                   inv ? ~pay : pay};
                    frame_full <= 1'b1;
                    ctrl_taken <= 1'b1;
                    run_disp <= inv ? run_disp - pd : run_disp + pd;
                end
            end
        end
    end

    // bit shifter; idle line alternates so the far end keeps bit timing
    reg [27:0] shreg;
    reg [4:0] bits_left;
    reg [7:0] div_cnt;
    reg idle_bit;
    wire bit_tick = (div_cnt == BIT_DIV - 1);

    always @* begin
        frame_load = pll_locked && bit_tick && (bits_left == 5'd0) && frame_full;
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg <= 28'h0;
            bits_left <= 5'd0;
            div_cnt <= 8'd0;
            idle_bit <= 1'b0;
            ser_out <= 1'b1;
        end else begin
            div_cnt <= bit_tick ? 8'd0 : div_cnt + 8'd1;
            if (!s_pdn) begin
                ser_out <= 1'b1;
                bits_left <= 5'd0;
            end else if (!pll_locked) begin
                bits_left <= 5'd0;
                if (bit_tick) begin
                    ser_out <= idle_bit;
                    idle_bit <= ~idle_bit;
                end
            end else if (bit_tick) begin
                if (bits_left != 5'd0) begin
                    ser_out <= shreg[27];
                    shreg <= {shreg[26:0], 1'b0};
                    bits_left <= bits_left - 5'd1;
                end else if (frame_full) begin
                    ser_out <= frame_hold[27];
                    shreg <= {frame_hold[26:0], 1'b0};
                    bits_left <= 5'd27;
                end else begin
                    ser_out <= idle_bit;
                    idle_bit <= ~idle_bit;
                end
            end
        end
    end

endmodule
`default_nettype wire

// *** sim/cps_imager.sv ***
// imager model driving the pixel bus at a 160 ns pixel period
`timescale 1ns/10ps
`default_nettype none
module cps_imager (
    input wire logic run,
    input wire logic cap_rise,
    output logic pixel_clk,
    output logic line_sync,
    output logic frame_sync,
    output logic [11:0] pixel_data
);
    int n = 0;
    initial begin
        pixel_clk = 1'b0;
        line_sync = 1'b0;
        frame_sync = 1'b0;
        pixel_data = 12'h0;
        forever begin
            #80;
            if (run)
                pixel_clk = ~pixel_clk;
            // data moves on the edge opposite the capture edge
            if (run && pixel_clk != cap_rise) begin
                n = n + 1;
                pixel_data = n[11:0];
                if (n % 12 == 0) line_sync = ~line_sync;
                if (n % 24 == 0) frame_sync = ~frame_sync;
            end else if (!run)
                pixel_data = ~pixel_data;
        end
    end
endmodule
`default_nettype wire

// *** sim/cps_monitor.sv ***
// port assertions for the camera pixel serializer
`timescale 1ns/10ps
`default_nettype none
module cps_monitor #(parameter LOCK_CYCLES = 100, parameter ACT_TIMEOUT = 256) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pixel_clk,
    input wire logic osc_clk,
    input wire logic power_down_n,
    input wire logic ref_select_osc,
    input wire logic ctrl_taken,
    input wire logic pll_locked,
    input wire logic ser_out
);
    logic [19:0] up;
    logic [5:0] unl;
    logic [11:0] qt;
    logic rq;
    wire rf = ref_select_osc ? osc_clk : pixel_clk;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            up <= 20'h0;
            unl <= 6'h0;
            qt <= 12'h0;
            rq <= 1'b0;
        end else begin
            up <= !power_down_n ? 20'h0 : up + {19'h0, up != 20'hfffff};
            unl <= (!power_down_n || pll_locked) ? 6'h0 : unl + {5'h0, unl != 6'h3f};
            qt <= (rf != rq) ? 12'h0 : qt + {11'h0, qt != 12'hfff};
            rq <= rf;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    a_pd_high: assert property ((!power_down_n)[*4] |-> ser_out)
        else $error("serial line low in power-down");
    a_pd_unlock: assert property ((!power_down_n)[*4] |-> !pll_locked)
        else $error("locked in power-down");
    a_lock_wait: assert property ($rose(pll_locked) |-> up >= LOCK_CYCLES)
        else $error("lock came too early");
    a_taken_gap: assert property (ctrl_taken |=> (!ctrl_taken)[*8])
        else $error("frames too close");
    a_taken_lock: assert property (ctrl_taken |-> $past(pll_locked))
        else $error("frame built while unlocked");
    a_idle_toggle: assert property (unl == 6'h3f |-> ser_out != $past(ser_out, 2))
        else $error("idle pattern not toggling");
    a_bit_hold: assert property (power_down_n[*4] ##0 $changed(ser_out) |=> $stable(ser_out))
        else $error("serial bit too short");
    a_ref_dead: assert property (qt > ACT_TIMEOUT + 8 |-> !pll_locked)
        else $error("locked without reference");
endmodule
bind cps_serializer cps_monitor #(.LOCK_CYCLES(LOCK_CYCLES), .ACT_TIMEOUT(ACT_TIMEOUT)) u_mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .pixel_clk(pixel_clk), .osc_clk(osc_clk),
    .power_down_n(power_down_n), .ref_select_osc(ref_select_osc), .ctrl_taken(ctrl_taken),
    .pll_locked(pll_locked), .ser_out(ser_out));
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the camera pixel serializer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, osc_clk = 1'b0, osc_run = 1'b0, run = 1'b0;
    logic power_down_n = 1'b0, capture_edge_select = 1'b1, wide_mode = 1'b0;
    logic ref_select_osc = 1'b0, ctrl_bit = 1'b0;
    wire pixel_clk, line_sync, frame_sync, ctrl_taken, pll_locked, ser_out;
    wire [11:0] pixel_data;
    int errors = 0, n_tests = 0;
    always #2 sys_clk = ~sys_clk;
    always #20 if (osc_run) osc_clk = ~osc_clk;
    always @(negedge sys_clk) ctrl_bit <= ~ctrl_bit;
    cps_imager u_cps_imager (.run(run), .cap_rise(capture_edge_select), .pixel_clk(pixel_clk),
        .line_sync(line_sync), .frame_sync(frame_sync), .pixel_data(pixel_data));
    cps_serializer #(.LOCK_CYCLES(100), .ACT_TIMEOUT(64), .BIT_DIV(2)) u_cps_serializer (
        .sys_clk(sys_clk), .rst_n(rst_n), .pixel_clk(pixel_clk), .osc_clk(osc_clk),
        .power_down_n(power_down_n), .capture_edge_select(capture_edge_select),
        .wide_mode(wide_mode), .ref_select_osc(ref_select_osc), .line_sync(line_sync),
        .frame_sync(frame_sync), .pixel_data(pixel_data), .ctrl_bit(ctrl_bit),
        .ctrl_taken(ctrl_taken), .pll_locked(pll_locked), .ser_out(ser_out));
    task automatic chk(input string name, input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %b, seen %b", name, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wait_lock(output int c);
        c = 0;
        while (pll_locked !== 1'b1) begin
            @(negedge sys_clk);
            c++;
            if (c > 2000) begin
                errors++;
                complete_run();
            end
        end
    endtask
    task automatic t_down(input logic up);
        power_down_n = up;
        repeat (300) @(negedge sys_clk);
    endtask
    task automatic t_stream(input logic e, input logic w, input int exp);
        int c;
        int f;
        logic prev;
        logic cb;
        logic [27:0] fr;
        capture_edge_select = e;
        wide_mode = w;
        power_down_n = 1'b1;
        wait_lock(c);
        chk("lock time", c >= 100 && c <= 200, 1'b1);
        c = 0;
        prev = ser_out;
        while (ctrl_taken !== 1'b1) begin
            prev = ser_out;
            @(negedge sys_clk);
            c++;
            if (c > 800) begin
                errors++;
                complete_run();
            end
        end
        chk("latency", c >= (w ? 470 : 0) && c <= 640, 1'b1);
        cb = ctrl_bit;
        // idle bits toggle every tick, so a change here marks the tick phase
        repeat ((ser_out !== prev) ? 2 : 1) @(negedge sys_clk);
        for (int i = 27; i >= 0; i--) begin
            fr[i] = ser_out;
            repeat (2) @(negedge sys_clk);
        end
        chk("marker", fr[27], 1'b1);
        chk("ctrl bit", fr[25], cb);
        chk("parity", fr[24], ^{fr[25], fr[23:0]});
        if (w)
            chk("wide pad", fr[23:21] === {3{fr[26]}}, 1'b1);
        f = 0;
        repeat (1200) begin
            @(negedge sys_clk);
            f += (ctrl_taken === 1'b1);
        end
        chk("frames", f >= exp - 1 && f <= exp + 1, 1'b1);
        power_down_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        chk("lock lost", pll_locked, 1'b0);
        chk("ser_out", ser_out, 1'b1);
    endtask
    task automatic t_ref(input logic osc);
        int c;
        ref_select_osc = osc;
        t_down(1'b1);
        chk("dead ref", pll_locked, 1'b0);
        run = ~osc;
        osc_run = osc;
        wait_lock(c);
        run = 1'b0;
        osc_run = 1'b0;
        t_down(1'b0);
        chk("ref lost", pll_locked, 1'b0);
        ref_select_osc = 1'b0;
        run = 1'b1;
    endtask
    initial begin
        repeat (12) @(negedge sys_clk);
        chk("reset lock", pll_locked, 1'b0);
        rst_n = 1'b1;
        run = 1'b1;
        t_down(1'b0);
        chk("pd ser_out", ser_out, 1'b1);
        t_stream(1'b1, 1'b0, 15);
        t_stream(1'b0, 1'b0, 15);
        t_stream(1'b1, 1'b1, 20);
        t_stream(1'b0, 1'b1, 20);
        run = 1'b0;
        t_ref(1'b0);
        t_ref(1'b1);
        t_stream(1'b1, 1'b0, 15);
        complete_run();
    end
endmodule
`default_nettype wire
